// file: src/cbc_ctrl.sv
// bus cycle sequencer: phases, halt, interrupt and start-up entry, bus drive
// assumes pins arrive asynchronously; core_* ports come from the same clock
// How it works
// - drive data only while bus_drive_enable high
// - read cycles never drive the data bus
// - halt on read holds address through phase two
// - halt ignored during write, taken next read
// - maskable request waits instruction end, mask clear
// - push pc and status, then set mask
// - maskable vector read from FFFE then FFFF
// - interrupts taken only while halt input high
// - unmaskable edge runs same sequence, ignores mask
// - unmaskable vector read from FFFA then FFFB
// - requests sampled phase two, start at phase one
// - overflow pin falling edge sets overflow bit
// - fetch marker high whole opcode fetch cycle
// - halt during fetch freezes until released
// - no writes while cold start held low
// - six init cycles, set mask, vector FFFC/FFFD
// - direction high for reads, low for writes
`timescale 1ns/1ps
`default_nettype none

module cbc_ctrl
    import cbc_pkg::*;
#(
    parameter int unsigned PH1_CYC = PH1_CYCLES,
    parameter int unsigned PH2_CYC = PH2_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        cold_start_n,
    input  wire logic        halt_request_in,
    input  wire logic        maskable_int_req_n,
    input  wire logic        unmaskable_int_req_n,
    input  wire logic        overflow_set_in,
    input  wire logic        bus_drive_enable,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe_n,
    output logic      [15:0] addr_out,
    output logic             transfer_direction,
    output logic             opcode_fetch_marker,
    output logic             phase1_out,
    output logic             phase2_out,
    input  wire logic        core_req_valid,
    output logic             core_req_ready,
    input  wire logic [15:0] core_addr,
    input  wire logic        core_write,
    input  wire logic [7:0]  core_wdata,
    input  wire logic        core_fetch,
    input  wire logic [15:0] core_pc,
    input  wire logic [7:0]  core_sp,
    input  wire logic        core_status_we,
    input  wire logic [7:0]  core_status_wdata,
    output logic             core_done,
    output logic      [7:0]  core_rdata,
    output logic             core_pc_load,
    output logic      [15:0] core_pc_new,
    output logic             core_sp_load,
    output logic      [7:0]  core_sp_new,
    output logic      [7:0]  status_out
);

    // refused at elaboration: the phase counter is eight bits wide
    if (PH1_CYC < 1 || PH1_CYC > 255 || PH2_CYC < 1 || PH2_CYC > 255) begin : g_bad_phase
        $error("phase lengths must lie in 1..255 cycles");
    end

    localparam logic [7:0] PH1_LAST = 8'(PH1_CYC - 1);
    localparam logic [7:0] PH2_LAST = 8'(PH2_CYC - 1);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam int unsigned NPIN = 14;
    // idle pin levels in reset, so short phases see no false edge or request;
    // cold start rests low so the sequencer waits in its hold state; drive enable and data also rest low
    localparam logic [NPIN-1:0] PIN_IDLE = 14'h001E;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic            cold_s;
    logic            halt_s;
    logic            irq_s;
    logic            nmi_s;
    logic            so_s;
    logic            dbe_s;
    logic [7:0]      din_s;

    assign pin_raw = {data_in, bus_drive_enable, overflow_set_in, unmaskable_int_req_n,
                      maskable_int_req_n, halt_request_in, cold_start_n};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign cold_s = pin_s2_q[0];
    assign halt_s = pin_s2_q[1];
    assign irq_s  = pin_s2_q[2];
    assign nmi_s  = pin_s2_q[3];
    assign so_s   = pin_s2_q[4];
    assign dbe_s  = pin_s2_q[5];
    assign din_s  = pin_s2_q[13:6];

    // ****************************************************************
    // phase generator
    // ****************************************************************
    cbc_phase_t ph_q;
    logic [7:0] cnt_q;
    logic       ph_end1;
    logic       ph_end2;
    logic       stall_q;
    logic       issue;

    assign ph_end1 = (ph_q == PH_ONE) && (cnt_q == PH1_LAST);
    assign ph_end2 = (ph_q == PH_TWO) && (cnt_q == PH2_LAST);
    assign issue   = ph_end2 && !stall_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_q  <= PH_ONE;
            cnt_q <= 8'h00;
        end else if (ph_end1) begin
            ph_q  <= PH_TWO;
            cnt_q <= 8'h00;
        end else if (ph_end2) begin
            ph_q  <= PH_ONE;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign phase1_out = (ph_q == PH_ONE);
    assign phase2_out = (ph_q == PH_TWO);

    // ****************************************************************
    // halt: decided at the end of phase one, the cycle then repeats
    // ****************************************************************
    cbc_kind_t   kind_q;
    logic        cur_wr_q;
    logic        cur_fetch_q;

    // halt is assumed steady through phase two, so one sample suffices
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stall_q <= 1'b0;
        end else if (ph_end1) begin
            stall_q <= !halt_s && !cur_wr_q;
        end
    end

    // ****************************************************************
    // interrupt sampling
    // ****************************************************************
    logic irq_lvl_q;
    logic nmi_prev_q;
    logic nmi_pend_q;
    logic nmi_fall;
    logic so_prev_q;
    logic so_fall;
    logic int_take;

    assign nmi_fall = ph_end2 && nmi_prev_q && !nmi_s;
    assign so_fall  = ph_end1 && so_prev_q && !so_s;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_lvl_q  <= 1'b0;
            nmi_prev_q <= 1'b1;
        end else if (ph_end2) begin
            irq_lvl_q  <= !irq_s;
            nmi_prev_q <= nmi_s;
        end
    end

    // a new edge in the cycle of the take survives: set wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_fall) begin
            nmi_pend_q <= 1'b1;
        end else if (issue && int_take && nmi_pend_q) begin
            nmi_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            so_prev_q <= 1'b1;
        end else if (ph_end1) begin
            so_prev_q <= so_s;
        end
    end

    // ****************************************************************
    // next bus cycle selection
    // ****************************************************************
    cbc_vec_t    vec_q;
    cbc_vec_t    nxt_vec;
    cbc_kind_t   nxt_kind;
    logic [15:0] nxt_addr;
    logic        nxt_wr;
    logic [7:0]  nxt_wdata;
    logic        nxt_fetch;
    logic        core_take;
    logic        int_want;
    logic [15:0] pc_snap_q;
    logic [7:0]  sp_snap_q;
    logic [7:0]  status_q;
    logic [2:0]  init_cnt_q;

    function automatic logic [15:0] vec_addr(input cbc_vec_t sel, input logic hi);
        logic [15:0] a;
        a = hi ? VEC_RST_HI : VEC_RST_LO;
        if (sel == VS_NMI) begin
            a = hi ? VEC_NMI_HI : VEC_NMI_LO;
        end else if (sel == VS_IRQ) begin
            a = hi ? VEC_IRQ_HI : VEC_IRQ_LO;
        end
        return a;
    endfunction

    function automatic logic [15:0] stack_addr(input logic [7:0] sp, input logic [7:0] off);
        logic [7:0] lo;
        lo = sp - off;
        return {STACK_PAGE, lo};
    endfunction

    // only at an opcode fetch has the previous instruction finished
    assign int_want = core_req_valid && core_fetch && halt_s &&
                      (nmi_pend_q || (irq_lvl_q && !status_q[MASK_BIT]));

    always_comb begin
        nxt_kind  = K_IDLE;
        nxt_vec   = vec_q;
        nxt_addr  = core_pc;
        nxt_wr    = 1'b0;
        nxt_wdata = 8'h00;
        nxt_fetch = 1'b0;
        int_take  = 1'b0;
        core_take = 1'b0;
        if (!cold_s) begin
            nxt_kind = K_HOLD;
        end else begin
            case (kind_q)
                K_HOLD: begin
                    nxt_kind = K_INIT;
                end
                K_INIT: begin
                    if (init_cnt_q == INIT_LAST) begin
                        nxt_kind = K_VEC_LO;
                        nxt_vec  = VS_RST;
                        nxt_addr = vec_addr(VS_RST, 1'b0);
                    end else begin
                        nxt_kind = K_INIT;
                    end
                end
                K_PUSH_H: begin
                    nxt_kind  = K_PUSH_L;
                    nxt_addr  = stack_addr(sp_snap_q, SP_STEP1);
                    nxt_wr    = 1'b1;
                    nxt_wdata = pc_snap_q[7:0];
                end
                K_PUSH_L: begin
                    nxt_kind  = K_PUSH_P;
                    nxt_addr  = stack_addr(sp_snap_q, SP_STEP2);
                    nxt_wr    = 1'b1;
                    nxt_wdata = status_q;
                end
                K_PUSH_P: begin
                    nxt_kind = K_VEC_LO;
                    nxt_addr = vec_addr(vec_q, 1'b0);
                end
                K_VEC_LO: begin
                    nxt_kind = K_VEC_HI;
                    nxt_addr = vec_addr(vec_q, 1'b1);
                end
                K_VEC_HI: begin
                    // one idle cycle lets the core take the new counter
                    nxt_kind = K_IDLE;
                end
                default: begin
                    if (int_want) begin
                        int_take  = 1'b1;
                        nxt_kind  = K_PUSH_H;
                        nxt_vec   = nmi_pend_q ? VS_NMI : VS_IRQ;
                        nxt_addr  = stack_addr(core_sp, 8'h00);
                        nxt_wr    = 1'b1;
                        nxt_wdata = core_pc[15:8];
                    end else if (core_req_valid) begin
                        core_take = 1'b1;
                        nxt_kind  = K_CORE;
                        nxt_addr  = core_addr;
                        nxt_wr    = core_write;
                        nxt_wdata = core_wdata;
                        nxt_fetch = core_fetch && !core_write;
                    end
                end
            endcase
        end
    end

    assign core_req_ready = issue && core_take;

    // ****************************************************************
    // current cycle registers, issued at the start of phase one
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kind_q      <= K_HOLD;
            vec_q       <= VS_RST;
            addr_out    <= 16'h0000;
            cur_wr_q    <= 1'b0;
            data_out    <= 8'h00;
            cur_fetch_q <= 1'b0;
        end else if (issue) begin
            kind_q      <= nxt_kind;
            vec_q       <= nxt_vec;
            addr_out    <= nxt_addr;
            cur_wr_q    <= nxt_wr;
            data_out    <= nxt_wdata;
            cur_fetch_q <= nxt_fetch;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_snap_q <= 16'h0000;
            sp_snap_q <= 8'h00;
        end else if (issue && int_take) begin
            pc_snap_q <= core_pc;
            sp_snap_q <= core_sp;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_q <= 3'h0;
        end else if (issue) begin
            init_cnt_q <= (kind_q == K_INIT) ? init_cnt_q + 3'h1 : 3'h0;
        end
    end

    // ****************************************************************
    // pins: direction, drive and fetch marker
    // ****************************************************************
    assign transfer_direction  = !(cur_wr_q && cold_s);
    assign data_oe_n           = !(cur_wr_q && cold_s && dbe_s);
    assign opcode_fetch_marker = cur_fetch_q;

    // ****************************************************************
    // status register: hardware sets win over a core write
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= core_status_we ? core_status_wdata : status_q;
            if (so_fall) begin
                status_q[OVF_BIT] <= 1'b1;
            end
            if (issue && nxt_kind == K_VEC_LO) begin
                status_q[MASK_BIT] <= 1'b1;
            end
        end
    end

    assign status_out = status_q;

    // ****************************************************************
    // completion towards the core
    // ****************************************************************
    logic [7:0] vec_lo_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vec_lo_q     <= 8'h00;
            core_done    <= 1'b0;
            core_rdata   <= 8'h00;
            core_pc_load <= 1'b0;
            core_pc_new  <= 16'h0000;
            core_sp_load <= 1'b0;
            core_sp_new  <= 8'h00;
        end else begin
            core_done    <= issue && kind_q == K_CORE;
            core_pc_load <= issue && kind_q == K_VEC_HI;
            core_sp_load <= issue && kind_q == K_VEC_HI && vec_q != VS_RST;
            if (issue && kind_q == K_CORE) begin
                core_rdata <= din_s;
            end
            if (issue && kind_q == K_VEC_LO) begin
                vec_lo_q <= din_s;
            end
            if (issue && kind_q == K_VEC_HI) begin
                core_pc_new <= {din_s, vec_lo_q};
                core_sp_new <= sp_snap_q - SP_STEP3;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_push_hi;
        kind_q == K_PUSH_H && cur_wr_q;
    endsequence

    sequence s_push_lo;
        kind_q == K_PUSH_L && cur_wr_q;
    endsequence

    a_drive_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !data_oe_n |-> dbe_s && cur_wr_q)
        else $error("data driven without enable");

    a_read_undriven: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (kind_q == K_VEC_LO || kind_q == K_INIT) |-> data_oe_n && transfer_direction)
        else $error("data driven in read cycle");

    a_halt_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ph_end2 && stall_q |=> $stable(addr_out) && ph_q == PH_ONE)
        else $error("address moved while halted");

    a_write_nohalt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ph_end1 && cur_wr_q |=> !stall_q)
        else $error("write cycle halted");

    a_irq_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
        issue && int_take && !nmi_pend_q |-> !status_q[MASK_BIT] && irq_lvl_q)
        else $error("masked request taken");

    a_push_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(kind_q == K_PUSH_H) |-> s_push_hi ##[1:520] s_push_lo)
        else $error("push sequence broken");

    a_mask_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(kind_q == K_VEC_LO) |-> status_q[MASK_BIT])
        else $error("mask not set at vector fetch");

    a_irq_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind_q == K_VEC_LO && vec_q == VS_IRQ |-> addr_out == VEC_IRQ_LO)
        else $error("wrong maskable vector");

    a_halt_noint: assert property (@(posedge clk_sys) disable iff (!rst_n)
        issue && int_take |-> halt_s)
        else $error("interrupt taken while halted");

    a_nmi_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind_q == K_VEC_HI && vec_q == VS_NMI |-> addr_out == VEC_NMI_HI)
        else $error("wrong unmaskable vector");

    a_entry_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(kind_q == K_PUSH_H) |-> ph_q == PH_ONE && cnt_q == 8'h00)
        else $error("sequence not started at phase one");

    a_ovf_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        so_fall |=> status_q[OVF_BIT])
        else $error("overflow bit not set");

    a_fetch_marker: assert property (@(posedge clk_sys) disable iff (!rst_n)
        opcode_fetch_marker |-> kind_q == K_CORE && !cur_wr_q)
        else $error("marker outside opcode fetch");

    a_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ph_end2 && stall_q |=> $stable(kind_q) && $stable(opcode_fetch_marker))
        else $error("state moved while frozen");

    a_no_write_cold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cold_s |-> data_oe_n && transfer_direction)
        else $error("write while cold start low");

    a_reset_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(kind_q == K_VEC_LO) && vec_q == VS_RST |-> addr_out == VEC_RST_LO
        && $past(init_cnt_q) == INIT_LAST)
        else $error("start-up vector wrong or early");

    a_push_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        kind_q == K_PUSH_P && cold_s |-> !transfer_direction)
        else $error("direction high on write");

    a_nmi_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        nmi_fall |=> nmi_pend_q)
        else $error("unmaskable edge lost");

endmodule

`default_nettype wire

// file: src/cbc_pkg.sv
// constants and types shared by the bus control and interrupt sequencer
// assumes a single 250 MHz system clock and a 16-bit address, 8-bit data bus
package cbc_pkg;

    // ****************************************************************
    // clock and phase timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned PH1_WIDTH_NS = 215;
    localparam int unsigned PH2_WIDTH_NS = 235;
    // least widths, so round up to whole cycles
    localparam int unsigned PH1_CYCLES   = (PH1_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PH2_CYCLES   = (PH2_WIDTH_NS * CLK_MHZ + 999) / 1000;

    // ****************************************************************
    // start-up sequence
    // ****************************************************************
    localparam logic [2:0]  INIT_LAST    = 3'h5;   // six bus cycles, counted 0..5

    // ****************************************************************
    // vectors, stack and status layout
    // ****************************************************************
    localparam logic [15:0] VEC_NMI_LO   = 16'hFFFA;
    localparam logic [15:0] VEC_NMI_HI   = 16'hFFFB;
    localparam logic [15:0] VEC_RST_LO   = 16'hFFFC;
    localparam logic [15:0] VEC_RST_HI   = 16'hFFFD;
    localparam logic [15:0] VEC_IRQ_LO   = 16'hFFFE;
    localparam logic [15:0] VEC_IRQ_HI   = 16'hFFFF;
    localparam logic [7:0]  STACK_PAGE   = 8'h01;
    localparam logic [7:0]  SP_STEP1     = 8'h01;
    localparam logic [7:0]  SP_STEP2     = 8'h02;
    localparam logic [7:0]  SP_STEP3     = 8'h03;
    localparam int unsigned OVF_BIT      = 6;
    localparam int unsigned MASK_BIT     = 2;
    localparam logic [7:0]  STATUS_RST   = 8'h00;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic {
        PH_ONE = 1'b0,
        PH_TWO = 1'b1
    } cbc_phase_t;

    typedef enum logic [3:0] {
        K_HOLD   = 4'b0000,
        K_INIT   = 4'b0001,
        K_IDLE   = 4'b0010,
        K_CORE   = 4'b0011,
        K_PUSH_H = 4'b0100,
        K_PUSH_L = 4'b0101,
        K_PUSH_P = 4'b0110,
        K_VEC_LO = 4'b0111,
        K_VEC_HI = 4'b1000
    } cbc_kind_t;

    typedef enum logic [1:0] {
        VS_RST = 2'b00,
        VS_NMI = 2'b01,
        VS_IRQ = 2'b10
    } cbc_vec_t;

endpackage

// file: verif/cbc_mem_model.sv
// memory and peripherals on the far side of the system bus
// assumes reads are answered at once from the current address
`timescale 1ns/1ps
`default_nettype none
module cbc_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] addr_out,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe_n,
    input  wire logic        transfer_direction,
    output logic      [7:0]  data_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i[7:0] ^ i[15:8] ^ 8'h5A);
        end
    end
    always @(posedge clk_sys) begin
        if (data_oe_n === 1'b0) mem[addr_out] <= data_out;
        last_q <= data_in;
    end
    // released bus shows a toggling pattern, never a stale byte
    assign data_in = transfer_direction ? mem[addr_out] : ~last_q;
endmodule
`default_nettype wire

// file: verif/tb_cpu_bus_control_interrupts.sv
// self-checking bench for the bus sequencer
// assumes the memory model answers reads; phases shortened to 4+2 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_control_interrupts;
    import cbc_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, cold_start_n = 1'b0, halt_request_in = 1'b1;
    logic maskable_int_req_n = 1'b1, unmaskable_int_req_n = 1'b1, overflow_set_in = 1'b1;
    logic bus_drive_enable = 1'b1, core_req_valid = 1'b0, core_write = 1'b0, core_fetch = 1'b0;
    logic core_status_we = 1'b0, core_req_ready, core_done, core_pc_load, core_sp_load;
    logic data_oe_n, transfer_direction, opcode_fetch_marker, phase1_out, phase2_out;
    logic [15:0] core_addr = 16'h0000, core_pc = 16'h1357, addr_out, core_pc_new, pcv;
    logic [7:0] core_wdata = 8'hA5, core_sp = 8'hF0, core_status_wdata = 8'h00;
    logic [7:0] data_in, data_out, core_rdata, core_sp_new, status_out, spv;
    int miscompares = 0, samples_checked = 0, dn = 0, pl = 0;
    cbc_ctrl #(.PH1_CYC(4), .PH2_CYC(2)) i_dut (.clk_sys, .rst_n, .cold_start_n,
        .halt_request_in, .maskable_int_req_n, .unmaskable_int_req_n, .overflow_set_in,
        .bus_drive_enable, .data_in, .data_out, .data_oe_n, .addr_out, .transfer_direction,
        .opcode_fetch_marker, .phase1_out, .phase2_out, .core_req_valid, .core_req_ready,
        .core_addr, .core_write, .core_wdata, .core_fetch, .core_pc, .core_sp, .core_status_we,
        .core_status_wdata, .core_done, .core_rdata, .core_pc_load, .core_pc_new,
        .core_sp_load, .core_sp_new, .status_out);
    cbc_mem_model u_mem (.clk_sys, .addr_out, .data_out, .data_oe_n, .transfer_direction,
        .data_in);
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        dn <= dn + int'(core_done === 1'b1);
        pl <= pl + int'(core_pc_load === 1'b1);
        if (core_pc_load === 1'b1) pcv <= core_pc_new;
        if (core_sp_load === 1'b1) spv <= core_sp_new;
    end
    function automatic logic [7:0] f(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // waits for the done or vector-load count to move on
    task automatic wt(input int base, input bit pc);
        int n = 0;
        while (((pc ? pl : dn) == base) && n < 100) begin
            tick(1);
            n++;
        end
        chk(16'(n < 100), 16'h1);
    endtask
    task automatic req(input logic [15:0] a, input logic w, input logic fe);
        int n = 0;
        core_addr = a;
        core_write = w;
        core_fetch = fe;
        core_req_valid = 1'b1;
        #1;  // let the combinational ready settle before it is read
        while (core_req_ready !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(16'(n < 200), 16'h1);
        tick(1);
        core_req_valid = 1'b0;
    endtask
    task automatic go(input logic [15:0] a, input logic w, input logic fe);
        int d = dn;
        req(a, w, fe);
        wt(d, 0);
    endtask
    // hold a fetch until a vector load, then refetch at the new counter
    task automatic ifetch();
        int p = pl;
        tick(14);
        core_fetch = 1'b1;
        core_write = 1'b0;
        core_req_valid = 1'b1;
        wt(p, 1);
        go(pcv, 1'b0, 1'b1);
    endtask
    task automatic t_start();
        tick(6);
        rst_n = 1'b1;
        tick(2);
        cold_start_n = 1'b1;
        wt(0, 1);
        chk(pcv, {f(16'hFFFD), f(16'hFFFC)});
        chk(16'(status_out[MASK_BIT]), 16'h1);
        $display("test start done");
    endtask
    task automatic t_rw();
        req(16'h1234, 1'b0, 1'b1);
        tick(1);
        chk(16'({opcode_fetch_marker, transfer_direction, data_oe_n, phase2_out}), 16'hE);
        wt(dn, 0);
        chk(16'(core_rdata), 16'(f(16'h1234)));
        req(16'h0200, 1'b1, 1'b0);
        tick(1);
        chk(16'({opcode_fetch_marker, transfer_direction, data_oe_n}), 16'h0);
        wt(dn, 0);
        chk(16'(u_mem.mem[16'h0200]), 16'h00A5);
        bus_drive_enable = 1'b0;
        req(16'h0201, 1'b1, 1'b0);
        tick(1);
        chk(16'(data_oe_n), 16'h1);
        wt(dn, 0);
        chk(16'(u_mem.mem[16'h0201]), 16'(f(16'h0201)));
        bus_drive_enable = 1'b1;
        $display("test read write done");
    endtask
    task automatic t_halt();
        int d = dn;
        req(16'h0300, 1'b0, 1'b1);
        halt_request_in = 1'b0;
        tick(12);
        chk(addr_out, 16'h0300);
        chk(16'(dn), 16'(d));
        while (phase1_out !== 1'b1) tick(1);
        halt_request_in = 1'b1;
        wt(d, 0);
        chk(16'(core_rdata), 16'(f(16'h0300)));
        req(16'h0202, 1'b1, 1'b0);
        halt_request_in = 1'b0;
        wt(d + 1, 0);
        tick(6);
        chk(16'(i_dut.stall_q), 16'h1);
        while (phase1_out !== 1'b1) tick(1);
        halt_request_in = 1'b1;
        $display("test halt done");
    endtask
    task automatic t_int();
        int p = pl;
        core_status_we = 1'b1;
        tick(1);
        core_status_we = 1'b0;
        maskable_int_req_n = 1'b0;
        ifetch();
        chk(pcv, {f(16'hFFFF), f(16'hFFFE)});
        chk(16'({status_out[MASK_BIT], spv}), 16'h01ED);
        chk({u_mem.mem[16'h01F0], u_mem.mem[16'h01EF]}, 16'h1357);
        go(16'h0410, 1'b0, 1'b1);
        chk(16'(pl), 16'(p + 1));
        maskable_int_req_n = 1'b1;
        unmaskable_int_req_n = 1'b0;
        ifetch();
        chk(pcv, {f(16'hFFFB), f(16'hFFFA)});
        go(16'h0510, 1'b0, 1'b1);
        chk(16'(pl), 16'(p + 2));
        unmaskable_int_req_n = 1'b1;
        overflow_set_in = 1'b0;
        tick(14);
        chk(16'(status_out[OVF_BIT]), 16'h1);
        $display("test interrupt done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        t_start();
        t_rw();
        t_halt();
        t_int();
        req(16'h0203, 1'b1, 1'b0);
        cold_start_n = 1'b0;
        tick(3);
        chk(16'({transfer_direction, data_oe_n}), 16'h3);
        end_sim();
    end
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
